// ---- shared/bram_regs.svh ----
/*
  Constants for the dual-port block memory: storage geometry, port widths,
  register offsets and field positions of the register file.
  Assumes inclusion by bare name from design files; definitions only.
*/
`ifndef BRAM_REGS_SVH
`define BRAM_REGS_SVH

// ----------------------------------------------------------------------
// Storage geometry
// ----------------------------------------------------------------------
`define BRAM_CAPACITY_BITS 18432
`define BRAM_DATA_BITS 16384
`define BRAM_WORD_AW 9
`define BRAM_DEPTH 512
`define BRAM_TOTAL_W 36
`define BRAM_DATA_W 32
`define BRAM_PAR_W 4
`define BRAM_PORT_AW 14
`define BRAM_SUB_MASK 5'h1F
`define BRAM_SUB_BITS 3'h5
`define BRAM_BYTE_LOG 3'h3
`define BRAM_MAX_LOG 3'h5
`define BRAM_MULT_HI_LSB 16

// ----------------------------------------------------------------------
// APB register byte offsets
// ----------------------------------------------------------------------
`define BRAM_CTRL_ADDR 12'h000
`define BRAM_SRVAL_A_ADDR 12'h004
`define BRAM_SRVAL_B_ADDR 12'h008
`define BRAM_SRVAL_PAR_ADDR 12'h00C
`define BRAM_STATUS_ADDR 12'h010

// ----------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------
`define CTRL_WIDTH_A_LSB 0
`define CTRL_WIDTH_B_LSB 3
`define CTRL_MODE_A_LSB 6
`define CTRL_MODE_B_LSB 8
`define CTRL_INV_A_LSB 10
`define CTRL_INV_B_LSB 14
`define CTRL_SINGLE_BIT 18
`define CTRL_USED_W 19
`define CTRL_RESET 19'h0_0000
`define SRVAL_RESET 32'h0000_0000
`define SRVAL_PAR_B_LSB 4

// Inversion field bits, per port
`define INV_CLK_BIT 0
`define INV_EN_BIT 1
`define INV_WE_BIT 2
`define INV_SSR_BIT 3

// Status register fields
`define STAT_COLLIDE_BIT 0
`define STAT_BADCFG_BIT 1

`endif

// ---- shared/bram_pkg.sv ----
/*
  Types shared by the dual-port block memory modules.
  Assumes bram_regs.svh is available on the include path.
*/
package bram_pkg;

    // Port width selection; the code is also log2 of the data width
    typedef enum logic [2:0] {
        WIDTH_1 = 3'h0,
        WIDTH_2 = 3'h1,
        WIDTH_4 = 3'h2,
        WIDTH_9 = 3'h3,
        WIDTH_18 = 3'h4,
        WIDTH_36 = 3'h5
    } width_t;

    // Output behaviour during a write
    typedef enum logic [1:0] {
        WRITE_FIRST = 2'h0,
        READ_FIRST = 2'h1,
        NO_CHANGE = 2'h2
    } write_mode_t;

endpackage : bram_pkg

// ---- shared/bram_mem_if.sv ----
/*
  Carrier between the port logic and the storage array: one request group
  per port (index 0 is port A, 1 is port B) and the registered read words.
  Assumes both sides run on the core clock.
*/
`timescale 1ns/1ps
`default_nettype none

interface bram_mem_if;
    logic [1:0] en;
    logic [1:0] we;
    logic [1:0][8:0] addr;
    logic [1:0][35:0] wdata;
    logic [1:0][35:0] wmask;
    logic [1:0][35:0] rdata;

    modport port (output en, output we, output addr, output wdata, output wmask, input rdata);
    modport store (input en, input we, input addr, input wdata, input wmask, output rdata);
endinterface : bram_mem_if

`default_nettype wire

// ---- hw/bram_store.sv ----
/*
  Storage array of 512 words of 36 bits with two bit-masked write ports
  and two registered read ports (read data is the word before the write).
  Assumes requests arrive synchronous to the core clock.
*/
`timescale 1ns/1ps
`default_nettype none
`include "bram_regs.svh"

module bram_store
    import bram_pkg::*;
(
    input wire logic i_core_clk,
    bram_mem_if.store mem
);

    logic [`BRAM_TOTAL_W-1:0] array_q [`BRAM_DEPTH];
    logic [1:0][`BRAM_TOTAL_W-1:0] rdata_q;
    logic [`BRAM_TOTAL_W-1:0] merged_a;
    logic [`BRAM_TOTAL_W-1:0] merged_b;

    always_comb
    begin
        merged_a = (array_q[mem.addr[0]] & ~mem.wmask[0]) | (mem.wdata[0] & mem.wmask[0]);
        merged_b = (array_q[mem.addr[1]] & ~mem.wmask[1]) | (mem.wdata[1] & mem.wmask[1]);
    end

    // ------------------------------------------------------------------
    // Writes: one array shared by both ports
    // ------------------------------------------------------------------
    always_ff @(posedge i_core_clk)
    begin
        // Same word from both ports: merge lanes; port B's bits win where the lanes overlap
        if (mem.we[0] && mem.we[1] && mem.addr[0] == mem.addr[1])
        begin
            array_q[mem.addr[0]] <= (merged_a & ~mem.wmask[1]) | (mem.wdata[1] & mem.wmask[1]);
        end
        else
        begin
            if (mem.we[0])
            begin
                array_q[mem.addr[0]] <= merged_a;
            end
            if (mem.we[1])
            begin
                array_q[mem.addr[1]] <= merged_b;
            end
        end
    end

    // ------------------------------------------------------------------
    // Reads: old contents, registered
    // ------------------------------------------------------------------
    always_ff @(posedge i_core_clk)
    begin
        for (int p = 0; p < 2; p++)
        begin
            if (mem.en[p])
            begin
                rdata_q[p] <= array_q[mem.addr[p]];
            end
        end
    end

    assign mem.rdata = rdata_q;

endmodule : bram_store

`default_nettype wire

// ---- hw/dual_port_block_ram.sv ----
/*
  Dual-port block memory with per-port width, write mode, control polarity
  and output set/reset value, configured over APB.
  Assumes all inputs, the port clock pins included, are synchronous to
  i_core_clk; a port clock must stay in each level for at least one cycle.
*/
// Function
// - Storage is 18,432 bits, 16,384 without parity, shared by ports A and B.
// - Each port has its own clock, control, address and data lines.
// - Either port reads and writes, and sees data written by the other.
// - Dual-port, or single-port with only port A active.
// - Each port independently 1, 2, 4, 9, 18 or 36 bits wide.
// - Total width is data plus parity: 8+1, 16+2, 32+4.
// - Address width is 14 minus log2 of data width.
// - Depth is two to the address width; capacity is width times depth.
// - Wide read returns consecutive narrow words concatenated.
// - Narrow read returns the wide word piece chosen by narrow address.
// - Parity bits stay with their own data byte across widths.
// - Controls active high and clock rising edge by default.
// - Each control input may be inverted individually.
// - Upper 16 data input bits are shared with multiplier operands.
// - Enable and write enable on an edge store data and parity.
// - Disabled port neither reads nor writes; outputs hold.
// - Output during write follows write-first, read-first or no-change.
// - Enabled read edge drives outputs with the addressed contents.
`timescale 1ns/1ps
`default_nettype none
`include "bram_regs.svh"

module dual_port_block_ram
    import bram_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_rst,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [11:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    input wire logic i_port_a_clock,
    input wire logic i_port_a_enable,
    input wire logic i_port_a_write_enable,
    input wire logic i_port_a_sync_output_set_reset,
    input wire logic [13:0] i_port_a_addr,
    input wire logic [31:0] i_port_a_write_data_in,
    input wire logic [3:0] i_port_a_parity_lane_in,
    output logic [31:0] o_port_a_read_data,
    output logic [3:0] o_port_a_parity_lane_out,
    input wire logic i_port_b_clock,
    input wire logic i_port_b_enable,
    input wire logic i_port_b_write_enable,
    input wire logic i_port_b_sync_output_set_reset,
    input wire logic [13:0] i_port_b_addr,
    input wire logic [31:0] i_port_b_write_data_in,
    input wire logic [3:0] i_port_b_parity_lane_in,
    output logic [31:0] o_port_b_read_data,
    output logic [3:0] o_port_b_parity_lane_out,
    output logic [15:0] o_mult_a_operand_hi,
    output logic [15:0] o_mult_b_operand_hi
);

    // ------------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------------
    logic [`CTRL_USED_W-1:0] ctrl_q;
    logic [31:0] srval_a_q;
    logic [31:0] srval_b_q;
    logic [7:0] srval_par_q;
    logic collide_q;
    logic [31:0] prdata_q;
    logic apb_wr;
    logic apb_setup;
    logic addr_ok;
    logic bad_cfg;
    logic collide_now;

    assign apb_wr = i_psel && i_penable && i_pwrite;
    assign apb_setup = i_psel && !i_penable;
    assign addr_ok = (i_paddr == `BRAM_CTRL_ADDR) || (i_paddr == `BRAM_SRVAL_A_ADDR) ||
                     (i_paddr == `BRAM_SRVAL_B_ADDR) || (i_paddr == `BRAM_SRVAL_PAR_ADDR) ||
                     (i_paddr == `BRAM_STATUS_ADDR);
    // Zero-wait slave
    assign o_pready = 1'b1;
    assign o_pslverr = i_psel && i_penable && !addr_ok;
    assign o_prdata = prdata_q;

    always_ff @(posedge i_core_clk)
    begin
        if (i_rst)
        begin
            ctrl_q <= `CTRL_RESET;
            srval_a_q <= `SRVAL_RESET;
            srval_b_q <= `SRVAL_RESET;
            srval_par_q <= 8'h00;
        end
        else if (apb_wr)
        begin
            if (i_paddr == `BRAM_CTRL_ADDR)
            begin
                ctrl_q <= i_pwdata[`CTRL_USED_W-1:0];
            end
            else if (i_paddr == `BRAM_SRVAL_A_ADDR)
            begin
                srval_a_q <= i_pwdata;
            end
            else if (i_paddr == `BRAM_SRVAL_B_ADDR)
            begin
                srval_b_q <= i_pwdata;
            end
            else if (i_paddr == `BRAM_SRVAL_PAR_ADDR)
            begin
                srval_par_q <= i_pwdata[7:0];
            end
        end
    end

    // Sticky collision flag, write one to clear; a new collision wins
    always_ff @(posedge i_core_clk)
    begin
        if (i_rst)
        begin
            collide_q <= 1'b0;
        end
        else if (collide_now)
        begin
            collide_q <= 1'b1;
        end
        else if (apb_wr && i_paddr == `BRAM_STATUS_ADDR && i_pwdata[`STAT_COLLIDE_BIT])
        begin
            collide_q <= 1'b0;
        end
    end

    // Read data captured in the setup phase so it stands through the access
    always_ff @(posedge i_core_clk)
    begin
        if (i_rst)
        begin
            prdata_q <= 32'h0000_0000;
        end
        else if (apb_setup && !i_pwrite)
        begin
            if (i_paddr == `BRAM_CTRL_ADDR)
            begin
                prdata_q <= 32'(ctrl_q);
            end
            else if (i_paddr == `BRAM_SRVAL_A_ADDR)
            begin
                prdata_q <= srval_a_q;
            end
            else if (i_paddr == `BRAM_SRVAL_B_ADDR)
            begin
                prdata_q <= srval_b_q;
            end
            else if (i_paddr == `BRAM_SRVAL_PAR_ADDR)
            begin
                prdata_q <= 32'(srval_par_q);
            end
            else if (i_paddr == `BRAM_STATUS_ADDR)
            begin
                prdata_q <= 32'({bad_cfg, collide_q});
            end
            else
            begin
                prdata_q <= 32'h0000_0000;
            end
        end
    end

    // ------------------------------------------------------------------
    // Port inputs gathered into arrays, index 0 = A, 1 = B
    // ------------------------------------------------------------------
    bram_mem_if mem_bus ();

    logic [1:0] clk_in;
    logic [1:0] en_in;
    logic [1:0] we_in;
    logic [1:0] ssr_in;
    logic [1:0][13:0] addr_in;
    logic [1:0][31:0] data_in;
    logic [1:0][3:0] par_in;
    logic [1:0][2:0] width_cfg;
    logic [1:0][1:0] mode_cfg;
    logic [1:0][3:0] inv_cfg;
    logic [1:0][35:0] srval;
    logic [1:0] port_live;

    assign clk_in = {i_port_b_clock, i_port_a_clock};
    assign en_in = {i_port_b_enable, i_port_a_enable};
    assign we_in = {i_port_b_write_enable, i_port_a_write_enable};
    assign ssr_in = {i_port_b_sync_output_set_reset, i_port_a_sync_output_set_reset};
    assign addr_in = {i_port_b_addr, i_port_a_addr};
    assign data_in = {i_port_b_write_data_in, i_port_a_write_data_in};
    assign par_in = {i_port_b_parity_lane_in, i_port_a_parity_lane_in};
    assign width_cfg = {ctrl_q[`CTRL_WIDTH_B_LSB +: 3], ctrl_q[`CTRL_WIDTH_A_LSB +: 3]};
    assign mode_cfg = {ctrl_q[`CTRL_MODE_B_LSB +: 2], ctrl_q[`CTRL_MODE_A_LSB +: 2]};
    assign inv_cfg = {ctrl_q[`CTRL_INV_B_LSB +: 4], ctrl_q[`CTRL_INV_A_LSB +: 4]};
    assign srval = {srval_par_q[`SRVAL_PAR_B_LSB +: 4], srval_b_q, srval_par_q[3:0], srval_a_q};
    // Single-port build keeps port B idle
    assign port_live = {!ctrl_q[`CTRL_SINGLE_BIT], 1'b1};
    // Unused width codes fall back to one bit and are flagged
    assign bad_cfg = (width_cfg[0] > `BRAM_MAX_LOG) || (width_cfg[1] > `BRAM_MAX_LOG);
    assign collide_now = mem_bus.we[0] && mem_bus.we[1] && (mem_bus.addr[0] == mem_bus.addr[1]) &&
                         |(mem_bus.wmask[0] & mem_bus.wmask[1]);

    // ------------------------------------------------------------------
    // Per-port logic
    // ------------------------------------------------------------------
    for (genvar p = 0; p < 2; p++)
    begin : g_port
        logic clk_prev_q;
        logic [2:0] lg;
        logic edge_hit;
        logic en_act;
        logic we_act;
        logic ssr_act;
        logic act;
        logic [4:0] sub;
        logic [4:0] dshift;
        logic [1:0] pshift;
        logic [31:0] dmask;
        logic [3:0] pmask;
        logic [31:0] dval;
        logic [3:0] pval;
        logic pend_q;
        logic pend_we_q;
        logic pend_ssr_q;
        logic [1:0] pend_mode_q;
        logic [4:0] pend_dshift_q;
        logic [1:0] pend_pshift_q;
        logic [31:0] pend_dmask_q;
        logic [3:0] pend_pmask_q;
        logic [31:0] pend_data_q;
        logic [3:0] pend_par_q;
        logic [31:0] rd_data;
        logic [3:0] rd_par;
        logic [31:0] dout_q;
        logic [3:0] pout_q;
        logic [15:0] mult_hi_q;

        assign lg = (width_cfg[p] > `BRAM_MAX_LOG) ? 3'h0 : width_cfg[p];
        // Polarity per control signal, default active high / rising
        assign edge_hit = inv_cfg[p][`INV_CLK_BIT] ? (clk_prev_q && !clk_in[p]) :
                                                     (!clk_prev_q && clk_in[p]);
        assign en_act = en_in[p] ^ inv_cfg[p][`INV_EN_BIT];
        assign we_act = we_in[p] ^ inv_cfg[p][`INV_WE_BIT];
        assign ssr_act = ssr_in[p] ^ inv_cfg[p][`INV_SSR_BIT];
        assign act = edge_hit && en_act && port_live[p];

        // Address splits into a storage word and a lane within it
        assign sub = addr_in[p][4:0] & (`BRAM_SUB_MASK >> lg);
        assign dshift = 5'(sub << lg);
        assign pshift = (lg >= `BRAM_BYTE_LOG) ? 2'(sub << (lg - `BRAM_BYTE_LOG)) : 2'h0;
        assign dmask = 32'((33'h0_0000_0002 << ((6'h1 << lg) - 6'h1)) - 33'h0_0000_0001);
        assign pmask = (lg >= `BRAM_BYTE_LOG) ?
                       4'((5'h02 << ((3'h1 << (lg - `BRAM_BYTE_LOG)) - 3'h1)) - 5'h01) : 4'h0;
        assign dval = data_in[p] & dmask;
        assign pval = par_in[p] & pmask;

        assign mem_bus.en[p] = act;
        assign mem_bus.we[p] = act && we_act;
        assign mem_bus.addr[p] = 9'(addr_in[p] >> (`BRAM_SUB_BITS - lg));
        assign mem_bus.wdata[p] = {4'(pval << pshift), 32'(dval << dshift)};
        assign mem_bus.wmask[p] = {4'(pmask << pshift), 32'(dmask << dshift)};

        always_ff @(posedge i_core_clk)
        begin
            if (i_rst)
            begin
                clk_prev_q <= 1'b0;
            end
            else
            begin
                clk_prev_q <= clk_in[p];
            end
        end

        // Operation held one cycle while the array returns its read word
        always_ff @(posedge i_core_clk)
        begin
            if (i_rst)
            begin
                pend_q <= 1'b0;
                pend_we_q <= 1'b0;
                pend_ssr_q <= 1'b0;
                pend_mode_q <= WRITE_FIRST;
                pend_dshift_q <= 5'h00;
                pend_pshift_q <= 2'h0;
                pend_dmask_q <= 32'h0000_0000;
                pend_pmask_q <= 4'h0;
                pend_data_q <= 32'h0000_0000;
                pend_par_q <= 4'h0;
            end
            else
            begin
                pend_q <= act;
                pend_we_q <= we_act;
                pend_ssr_q <= ssr_act;
                pend_mode_q <= mode_cfg[p];
                pend_dshift_q <= dshift;
                pend_pshift_q <= pshift;
                pend_dmask_q <= dmask;
                pend_pmask_q <= pmask;
                pend_data_q <= dval;
                pend_par_q <= pval;
            end
        end

        assign rd_data = 32'(mem_bus.rdata[p][31:0] >> pend_dshift_q) & pend_dmask_q;
        assign rd_par = 4'(mem_bus.rdata[p][35:32] >> pend_pshift_q) & pend_pmask_q;

        always_ff @(posedge i_core_clk)
        begin
            if (i_rst)
            begin
                dout_q <= 32'h0000_0000;
                pout_q <= 4'h0;
            end
            else if (pend_q)
            begin
                if (pend_ssr_q)
                begin
                    dout_q <= srval[p][31:0] & pend_dmask_q;
                    pout_q <= srval[p][35:32] & pend_pmask_q;
                end
                else if (!pend_we_q)
                begin
                    dout_q <= rd_data;
                    pout_q <= rd_par;
                end
                else
                begin
                    case (pend_mode_q)
                        READ_FIRST:
                        begin
                            dout_q <= rd_data;
                            pout_q <= rd_par;
                        end
                        NO_CHANGE:
                        begin
                            dout_q <= dout_q;
                            pout_q <= pout_q;
                        end
                        default:
                        begin
                            dout_q <= pend_data_q;
                            pout_q <= pend_par_q;
                        end
                    endcase
                end
            end
        end

        // Shared operand wiring; the fabric must not drive both uses at once
        always_ff @(posedge i_core_clk)
        begin
            if (i_rst)
            begin
                mult_hi_q <= 16'h0000;
            end
            else
            begin
                mult_hi_q <= data_in[p][31:`BRAM_MULT_HI_LSB];
            end
        end
    end

    assign o_port_a_read_data = g_port[0].dout_q;
    assign o_port_a_parity_lane_out = g_port[0].pout_q;
    assign o_port_b_read_data = g_port[1].dout_q;
    assign o_port_b_parity_lane_out = g_port[1].pout_q;
    assign o_mult_a_operand_hi = g_port[0].mult_hi_q;
    assign o_mult_b_operand_hi = g_port[1].mult_hi_q;

    // ------------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------------
    bram_store u_store (
        .i_core_clk(i_core_clk),
        .mem(mem_bus.store)
    );

endmodule : dual_port_block_ram

`default_nettype wire

// ---- test/fabric_port.sv ----
/*
  Fabric-side model of one port clock pin.
  Assumes go is a one-cycle pulse on the core clock, at most every 4 cycles.
*/
`timescale 1ns/1ps
`default_nettype none
module fabric_port (
    input wire logic i_core_clk,
    input wire logic i_rst,
    input wire logic i_go,
    output logic o_pin
);
    logic [1:0] cnt_q;
    // Pin idles low; two cycles high keeps each level over one core cycle
    always_ff @(posedge i_core_clk)
    begin
        if (i_rst)
            cnt_q <= 2'h0;
        else if (i_go)
            cnt_q <= 2'h2;
        else if (cnt_q != 2'h0)
            cnt_q <= cnt_q - 2'h1;
    end
    assign o_pin = (cnt_q != 2'h0);
endmodule : fabric_port
`default_nettype wire

// ---- test/dual_port_block_ram_chk.sv ----
/*
  Port-level checker for the dual-port block memory.
  Assumes a bind onto the top module; shadows the control word from APB.
*/
`timescale 1ns/1ps
`default_nettype none
module dpbr_chk (
    input wire logic i_core_clk,
    input wire logic i_rst,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [11:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic o_pslverr,
    input wire logic i_port_a_clock,
    input wire logic i_port_b_clock,
    input wire logic [31:0] i_port_a_write_data_in,
    input wire logic [31:0] i_port_b_write_data_in,
    input wire logic [31:0] o_port_a_read_data,
    input wire logic [31:0] o_port_b_read_data,
    input wire logic [3:0] o_port_b_parity_lane_out,
    input wire logic [15:0] o_mult_a_operand_hi,
    input wire logic [15:0] o_mult_b_operand_hi
);
    logic [18:0] ctrl_q;
    logic [31:0] wa_q;
    logic [31:0] wb_q;
    always_ff @(posedge i_core_clk)
    begin
        if (i_rst)
            ctrl_q <= 19'h0_0000;
        else if (i_psel && i_penable && i_pwrite && i_paddr == 12'h000)
            ctrl_q <= i_pwdata[18:0];
    end
    always_ff @(posedge i_core_clk)
    begin
        wa_q <= i_port_a_write_data_in;
        wb_q <= i_port_b_write_data_in;
    end
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (i_rst);
    // No active edge can be pending once the pin has sat still this long
    sequence quiet_a; $stable(i_port_a_clock) [*3]; endsequence
    sequence quiet_b; $stable(i_port_b_clock) [*3]; endsequence
    hold_a_a: assert property (quiet_a |-> $stable(o_port_a_read_data)) else $error("port a moved");
    hold_b_a: assert property (quiet_b |-> $stable(o_port_b_read_data)) else $error("port b moved");
    mult_a_a: assert property (!$past(i_rst) |-> o_mult_a_operand_hi == wa_q[31:16]) else $error("mult a");
    mult_b_a: assert property (!$past(i_rst) |-> o_mult_b_operand_hi == wb_q[31:16]) else $error("mult b");
    nopar_b_a: assert property (ctrl_q[5:3] < 3'h3 && !$stable(o_port_b_read_data)
        |-> o_port_b_parity_lane_out == 4'h0) else $error("parity on narrow b");
    byte_b_a: assert property (ctrl_q[5:3] == 3'h3 |-> o_port_b_read_data[31:8] == 24'h00_0000)
        else $error("b wider than byte");
    single_b_a: assert property (ctrl_q[18] |-> $stable(o_port_b_read_data)) else $error("b live");
    bad_addr_a: assert property (i_psel && i_penable && i_paddr > 12'h010 |-> o_pslverr) else $error("no slverr");
endmodule : dpbr_chk
bind dual_port_block_ram dpbr_chk u_chk (.i_core_clk, .i_rst, .i_psel, .i_penable, .i_pwrite, .i_paddr,
    .i_pwdata, .o_pslverr, .i_port_a_clock, .i_port_b_clock, .i_port_a_write_data_in, .i_port_b_write_data_in,
    .o_port_a_read_data, .o_port_b_read_data, .o_port_b_parity_lane_out, .o_mult_a_operand_hi,
    .o_mult_b_operand_hi);
`default_nettype wire

// ---- test/dual_port_block_ram_bench.sv ----
/*
  Self-checking bench for the dual-port block memory.
  Assumes fabric_port drives both port clocks; APB configures the block.
*/
`timescale 1ns/1ps
`default_nettype none
module dual_port_block_ram_bench;
    logic clk, rst, psel, pen, pwr, pready, pslverr, err;
    logic [11:0] padr;
    logic [31:0] pwd, prdata, prd;
    logic [1:0] go, pin, en, we, ss;
    logic [1:0][13:0] ad;
    logic [1:0][31:0] di, dq;
    logic [1:0][3:0] dp, pq;
    int n_fail, comparisons;
    always #5 clk = ~clk;
    fabric_port u_pa (.i_core_clk(clk), .i_rst(rst), .i_go(go[0]), .o_pin(pin[0]));
    fabric_port u_pb (.i_core_clk(clk), .i_rst(rst), .i_go(go[1]), .o_pin(pin[1]));
    dual_port_block_ram dut (.i_core_clk(clk), .i_rst(rst), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
        .i_paddr(padr), .i_pwdata(pwd), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
        .i_port_a_clock(pin[0]), .i_port_a_enable(en[0]), .i_port_a_write_enable(we[0]),
        .i_port_a_sync_output_set_reset(ss[0]), .i_port_a_addr(ad[0]), .i_port_a_write_data_in(di[0]),
        .i_port_a_parity_lane_in(dp[0]), .o_port_a_read_data(dq[0]), .o_port_a_parity_lane_out(pq[0]),
        .i_port_b_clock(pin[1]), .i_port_b_enable(en[1]), .i_port_b_write_enable(we[1]),
        .i_port_b_sync_output_set_reset(ss[1]), .i_port_b_addr(ad[1]), .i_port_b_write_data_in(di[1]),
        .i_port_b_parity_lane_in(dp[1]), .o_port_b_read_data(dq[1]), .o_port_b_parity_lane_out(pq[1]),
        .o_mult_a_operand_hi(), .o_mult_b_operand_hi());
    task automatic chk(input logic [35:0] g, input logic [35:0] e);
        comparisons++;
        if (g !== e)
        begin
            n_fail++;
            $display("[ERR] %0t got %h exp %h", $time, g, e);
        end
    endtask : chk
    task automatic report_and_stop;
        if (n_fail == 0 && comparisons > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : report_and_stop
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int i = 0;
        psel <= 1'h1;
        pwr <= w;
        padr <= a;
        pwd <= d;
        @(posedge clk);
        pen <= 1'h1;
        @(posedge clk);
        while (pready !== 1'h1 && i < 16)
        begin
            i++;
            @(posedge clk);
        end
        prd = prdata;
        err = pslverr;
        psel <= 1'h0;
        pen <= 1'h0;
        if (i == 16)
        begin
            n_fail++;
            report_and_stop();
        end
        @(posedge clk);
    endtask : apb
    // One port edge; the pin model keeps the clock still outside it
    task automatic op(input int p, input logic e, input logic w, input logic s, input logic [13:0] a,
        input logic [31:0] d, input logic [3:0] q, input logic [35:0] x);
        en[p] <= e;
        we[p] <= w;
        ss[p] <= s;
        ad[p] <= a;
        di[p] <= d;
        dp[p] <= q;
        go[p] <= 1'h1;
        @(posedge clk);
        go[p] <= 1'h0;
        repeat (3) @(posedge clk);
        #1;
        chk({pq[p], dq[p]}, x);
    endtask : op
    initial
    begin
        {clk, psel, pen, pwr, padr, pwd, go, en, we, ss, ad, di, dp} = '0;
        rst = 1'h1;
        n_fail = 0;
        comparisons = 0;
        repeat (12) @(posedge clk);
        rst <= 1'h0;
        @(posedge clk);
        apb(0, 12'h010, 32'h0);
        chk({4'h0, prd}, 36'h0);
        apb(0, 12'h020, 32'h0);
        chk({3'h0, err, prd}, 36'h1_0000_0000);
        apb(1, 12'h000, 32'h0000_001D);
        apb(0, 12'h000, 32'h0);
        chk({4'h0, prd}, 36'h0_0000_001D);
        op(0, 1, 1, 0, 0, 32'h4433_2211, 4'hA, 36'hA_4433_2211);
        for (int k = 0; k < 4; k++)
            op(1, 1, 0, 0, 14'(k), 0, 0, (36'(k % 2) << 32) | 36'(8'h11 * (k + 1)));
        for (int k = 0; k < 4; k++)
            op(1, 1, 1, 0, 14'(k + 4), 32'(8'hA0 + k), 4'(k % 2), (36'(k % 2) << 32) | 36'(8'hA0 + k));
        op(0, 1, 0, 0, 1, 0, 0, 36'hA_A3A2_A1A0);
        op(0, 0, 1, 0, 0, 32'hFFFF_FFFF, 4'hF, 36'hA_A3A2_A1A0);
        op(0, 1, 0, 0, 0, 0, 0, 36'hA_4433_2211);
        apb(1, 12'h004, 32'h1234_5678);
        apb(1, 12'h00C, 32'h0000_0005);
        op(0, 1, 0, 1, 0, 0, 0, 36'h5_1234_5678);
        op(0, 1, 0, 0, 0, 0, 0, 36'hA_4433_2211);
        apb(1, 12'h000, 32'h0000_005D);
        op(0, 1, 1, 0, 0, 32'hDEAD_BEEF, 4'h3, 36'hA_4433_2211);
        apb(1, 12'h000, 32'h0000_081D);
        op(0, 0, 0, 0, 0, 0, 0, 36'h3_DEAD_BEEF);
        apb(1, 12'h000, 32'h0000_0005);
        op(1, 1, 0, 0, 4, 0, 0, 36'h0);
        op(1, 1, 0, 0, 5, 0, 0, 36'h1);
        apb(1, 12'h000, 32'h0004_0005);
        op(1, 1, 0, 0, 4, 0, 0, 36'h1);
        report_and_stop();
    end
endmodule : dual_port_block_ram_bench
`default_nettype wire
